//--- inc/mca_pkg.sv
// package: types, register map and timing constants of the microcore alu datapath
`default_nettype none
package mca_pkg;
	localparam int DW         = 16;
	localparam int PW         = 32;
	localparam int NREG       = 8;
	localparam int RIW        = 3;
	localparam int MUL_CYCLES = 17;
	localparam int IRQ_W      = 3;
	localparam int IRQ_DONE   = 0;
	localparam int IRQ_ARITH  = 1;
	localparam int IRQ_IGN    = 2;

	localparam logic [7:0] OFF_CMD  = 8'h00;
	localparam logic [7:0] OFF_COND = 8'h04;
	localparam logic [7:0] OFF_IMM  = 8'h08;
	localparam logic [7:0] OFF_PLO  = 8'h0c;
	localparam logic [7:0] OFF_PHI  = 8'h10;
	localparam logic [7:0] OFF_IST  = 8'h14;
	localparam logic [7:0] OFF_IMSK = 8'h18;
	localparam logic [7:0] OFF_REG0 = 8'h20;

	// operation-done reads high out of reset: nothing is pending
	localparam logic [15:0] COND_RST = 16'h0200;

	typedef enum logic [4:0] {
		OP_NOP, OP_ADD, OP_ADDI, OP_SUB, OP_SUBI, OP_MUL, OP_MULI,
		OP_AND, OP_OR, OP_XOR, OP_NOT,
		OP_WIDE_SHL, OP_WIDE_SHR, OP_WIDE_SHLI, OP_WIDE_SHRI,
		OP_SHL, OP_SHR, OP_SHLI, OP_SHRI, OP_SHLS, OP_SHRS, OP_SHLSI, OP_SHRSI,
		OP_BYTE_SHL, OP_BYTE_SHR, OP_SWAP, OP_TO_TWOS, OP_TO_INT, OP_SET_MODE
	} mca_op_t;

	typedef struct packed {
		logic rst_sel;
		logic [3:0] imm;
		logic [2:0] src;
		logic [2:0] dst;
		mca_op_t op;
	} mca_cmd_t;

	typedef struct packed {
		logic carry;
		logic zero_result_flag;
		logic negative_flag;
		logic unsigned_borrow_flag;
		logic unsigned_carry_flag;
		logic signed_under_flag;
		logic signed_over_flag;
	} mca_arith_t;

	typedef struct packed {
		logic [1:0] spare;
		logic       arith_mode_high_bit;
		logic       arith_mode_low_bit;
		logic       conv_sign;
		logic       shift_out;
		logic       operation_done_flag;
		logic       product_precision_loss_flag;
		logic       product_shift_overflow_flag;
		mca_arith_t ar;
	} mca_cond_t;
endpackage
`default_nettype wire

//--- logic/mca_addsub.sv
// 16-bit adder/subtractor with mode-dependent flag reporting
`default_nettype none
module mca_addsub
	import mca_pkg::*;
(
	input  wire logic [DW-1:0] a,
	input  wire logic [DW-1:0] b,
	input  wire logic          sub,
	input  wire logic [1:0]    mode,
	output logic [DW-1:0]      res,
	output mca_arith_t         fl
);
	logic [DW:0] sum;
	logic        ovf;
	wire         report_s = mode[0] | mode[1];
	wire         report_u = ~mode[0] | mode[1];

	assign sum = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
	assign res = sum[DW-1:0];
	assign ovf = sub ? (a[DW-1] != b[DW-1]) && (res[DW-1] != a[DW-1])
	                 : (a[DW-1] == b[DW-1]) && (res[DW-1] != a[DW-1]);

	assign fl.carry                = sum[DW];
	assign fl.zero_result_flag     = res == 16'h0000;
	// unsigned mode calls a result negative only when a subtraction borrowed
	assign fl.negative_flag        = mode[0] ? res[DW-1] : (sub & sum[DW]);
	assign fl.unsigned_borrow_flag = report_u & sub & sum[DW];
	assign fl.unsigned_carry_flag  = report_u & ~sub & sum[DW];
	assign fl.signed_under_flag    = report_s & ovf & a[DW-1];
	assign fl.signed_over_flag     = report_s & ovf & ~a[DW-1];
endmodule
`default_nettype wire

//--- logic/mca_alu.sv
// microcore alu datapath: register file, arithmetic, masks, shifts, conversion, multiply, apb slave
//
// The APB slave port and the placing of the registers were decided locally.
`default_nettype none
module mca_alu
	import mca_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq
);
	logic [DW-1:0]    reg_r [NREG];
	logic [DW-1:0]    imm_r;
	logic [PW-1:0]    prod_r;
	mca_cond_t        cond_r;
	mca_cond_t        cond_nxt;
	mca_cond_t        wcond;
	logic [IRQ_W-1:0] ist_r;
	logic [IRQ_W-1:0] ist_nxt;
	logic [IRQ_W-1:0] imsk_r;
	logic             ack_r;
	logic [31:0]      prdata_r;
	logic [31:0]      rd_mux;
	mca_cmd_t         cmd;
	logic             sh_busy_r;
	logic             sh_wide_r;
	logic             sh_left_r;
	logic             sh_sgn_r;
	logic [DW-1:0]    sh_cnt_r;
	logic [RIW-1:0]   sh_dst_r;
	logic [PW-1:0]    sh_val_r;
	logic [PW-1:0]    sh_val_nxt;
	logic             sh_out;
	logic             sh_ovf;
	logic [DW-1:0]    op_res;
	logic             op_we;
	logic [DW-1:0]    as_res;
	mca_arith_t       as_fl;
	logic             mul_busy;
	logic             mul_done;
	logic [PW-1:0]    mul_prod;

	// apb: one wait state so that read data leave a flop
	wire            acc_ph   = psel & penable;
	assign pready            = acc_ph & ack_r;
	wire            wr_en    = pready & pwrite;
	wire            aligned  = paddr[1:0] == 2'b00;
	wire            hit_cmd  = paddr == OFF_CMD;
	wire            hit_cond = paddr == OFF_COND;
	wire            hit_imm  = paddr == OFF_IMM;
	wire            hit_plo  = paddr == OFF_PLO;
	wire            hit_phi  = paddr == OFF_PHI;
	wire            hit_ist  = paddr == OFF_IST;
	wire            hit_imsk = paddr == OFF_IMSK;
	wire            hit_reg  = aligned & (paddr[7:5] == OFF_REG0[7:5]);
	wire [RIW-1:0]  apb_idx  = paddr[4:2];
	wire            mapped   = hit_cmd | hit_cond | hit_imm | hit_plo | hit_phi | hit_ist | hit_imsk | hit_reg;
	assign pslverr           = pready & ~mapped;
	assign prdata            = prdata_r;

	always_comb begin
		rd_mux = 32'h0;
		if (hit_reg)
			rd_mux = {16'h0000, reg_r[apb_idx]};
		else if (hit_cond)
			rd_mux = {16'h0000, cond_r};
		else if (hit_imm)
			rd_mux = {16'h0000, imm_r};
		else if (hit_plo)
			rd_mux = {16'h0000, prod_r[DW-1:0]};
		else if (hit_phi)
			rd_mux = {16'h0000, prod_r[PW-1:DW]};
		else if (hit_ist)
			rd_mux = {29'h0, ist_r};
		else if (hit_imsk)
			rd_mux = {29'h0, imsk_r};
	end

	// command decode
	assign cmd  = mca_cmd_t'(pwdata[DW-1:0]);
	assign wcond = mca_cond_t'(pwdata[DW-1:0]);
	wire launch    = wr_en & hit_cmd;
	wire busy      = sh_busy_r | mul_busy;
	wire is_mode   = cmd.op == OP_SET_MODE;
	wire accept    = launch & (~busy | is_mode);
	wire ignored   = launch & busy & ~is_mode;
	wire is_addsub = cmd.op inside {OP_ADD, OP_ADDI, OP_SUB, OP_SUBI};
	wire is_sub    = cmd.op inside {OP_SUB, OP_SUBI};
	wire is_mul    = cmd.op inside {OP_MUL, OP_MULI};
	wire is_wsh    = cmd.op inside {OP_WIDE_SHL, OP_WIDE_SHR, OP_WIDE_SHLI, OP_WIDE_SHRI};
	wire is_rsh    = cmd.op inside {OP_SHL, OP_SHR, OP_SHLI, OP_SHRI, OP_SHLS, OP_SHRS, OP_SHLSI, OP_SHRSI};
	wire op_left   = cmd.op inside {OP_WIDE_SHL, OP_WIDE_SHLI, OP_SHL, OP_SHLI, OP_SHLS, OP_SHLSI};
	wire op_sgn    = cmd.op inside {OP_SHLS, OP_SHRS, OP_SHLSI, OP_SHRSI};
	wire use_imm   = cmd.op inside {OP_ADDI, OP_SUBI, OP_MULI, OP_WIDE_SHLI, OP_WIDE_SHRI,
	                                OP_SHLI, OP_SHRI, OP_SHLSI, OP_SHRSI};
	wire [DW-1:0] dst_v = reg_r[cmd.dst];
	wire [DW-1:0] opb   = use_imm ? {12'h000, cmd.imm} : reg_r[cmd.src];
	wire          sh_start = accept & (is_wsh | is_rsh) & (opb != 16'h0000);

	mca_addsub u_addsub (
		.a    (dst_v),
		.b    (opb),
		.sub  (is_sub),
		.mode ({cond_r.arith_mode_high_bit, cond_r.arith_mode_low_bit}),
		.res  (as_res),
		.fl   (as_fl)
	);

	mca_mul u_mul (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (accept & is_mul),
		.mcand   (dst_v),
		.mplier  (opb),
		.busy    (mul_busy),
		.done    (mul_done),
		.product (mul_prod)
	);

	// single-cycle results, written to the destination at the issuing edge
	always_comb begin
		op_res = dst_v;
		op_we  = 1'b1;
		case (cmd.op)
			OP_ADD, OP_ADDI, OP_SUB, OP_SUBI: op_res = as_res;
			OP_AND:      op_res = dst_v & imm_r;
			OP_OR:       op_res = dst_v | imm_r;
			OP_XOR:      op_res = dst_v ^ imm_r;
			OP_NOT:      op_res = ~dst_v;
			OP_BYTE_SHL: op_res = {dst_v[7:0], 8'h00};
			OP_BYTE_SHR: op_res = {8'h00, dst_v[15:8]};
			OP_SWAP:     op_res = {dst_v[7:0], dst_v[15:8]};
			OP_TO_TWOS:  op_res = {cond_r.conv_sign, dst_v[14:0]};
			OP_TO_INT:   op_res = {1'b0, dst_v[14:0]};
			default:     op_we  = 1'b0;
		endcase
	end

	// one shift position per cycle; a signed left shift keeps the sign bit in place
	wire sh_last = sh_busy_r & (sh_cnt_r == 16'h0001);
	always_comb begin
		sh_val_nxt = {1'b0, sh_val_r[PW-1:1]};
		sh_out     = sh_val_r[0];
		sh_ovf     = 1'b0;
		if (sh_left_r) begin
			sh_val_nxt = {sh_val_r[PW-2:0], 1'b0};
			if (sh_wide_r) begin
				sh_out = sh_val_r[PW-1];
				sh_ovf = sh_out;
			end else if (sh_sgn_r) begin
				sh_out     = sh_val_r[DW-2];
				sh_ovf     = sh_out ^ sh_val_r[DW-1];
				sh_val_nxt = {16'h0000, sh_val_r[DW-1], sh_val_r[DW-3:0], 1'b0};
			end else begin
				sh_out     = sh_val_r[DW-1];
				sh_ovf     = sh_out;
				sh_val_nxt = {16'h0000, sh_val_r[DW-2:0], 1'b0};
			end
		end else if (sh_sgn_r) begin
			sh_val_nxt[DW-1] = sh_val_r[DW-1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_busy_r <= 1'b0;
			sh_wide_r <= 1'b0;
			sh_left_r <= 1'b0;
			sh_sgn_r  <= 1'b0;
			sh_cnt_r  <= 16'h0000;
			sh_dst_r  <= 3'h0;
			sh_val_r  <= 32'h0;
		end else if (sh_start) begin
			sh_busy_r <= 1'b1;
			sh_wide_r <= is_wsh;
			sh_left_r <= op_left;
			sh_sgn_r  <= op_sgn;
			sh_cnt_r  <= opb;
			sh_dst_r  <= cmd.dst;
			sh_val_r  <= is_wsh ? prod_r : {16'h0000, dst_v};
		end else if (sh_busy_r) begin
			sh_val_r  <= sh_val_nxt;
			sh_cnt_r  <= sh_cnt_r - 16'h0001;
			if (sh_last)
				sh_busy_r <= 1'b0;
		end
	end

	// register file: shift write-back wins over a bus write landing in the same cycle
	wire            sh_reg_wb  = sh_last & ~sh_wide_r;
	wire            op_reg_wb  = accept & op_we;
	wire            apb_reg_wb = wr_en & hit_reg;
	wire            wb_any     = sh_reg_wb | op_reg_wb | apb_reg_wb;
	wire [RIW-1:0]  wb_idx     = sh_reg_wb ? sh_dst_r : op_reg_wb ? cmd.dst : apb_idx;
	wire [DW-1:0]   wb_dat     = sh_reg_wb ? sh_val_nxt[DW-1:0] : op_reg_wb ? op_res : pwdata[DW-1:0];

	for (genvar gi = 0; gi < NREG; gi++) begin : g_reg
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				reg_r[gi] <= 16'h0000;
			else if (wb_any && wb_idx == RIW'(gi))
				reg_r[gi] <= wb_dat;
		end
	end

	// condition register
	always_comb begin
		cond_nxt = cond_r;
		if (wr_en && hit_cond) begin
			cond_nxt.arith_mode_high_bit = wcond.arith_mode_high_bit;
			cond_nxt.arith_mode_low_bit  = wcond.arith_mode_low_bit;
			cond_nxt.conv_sign           = wcond.conv_sign;
		end
		if (accept) begin
			case (cmd.op)
				OP_ADD, OP_ADDI, OP_SUB, OP_SUBI: cond_nxt.ar = as_fl;
				OP_SET_MODE: begin
					cond_nxt.arith_mode_high_bit = cmd.imm[1];
					cond_nxt.arith_mode_low_bit  = cmd.imm[0];
				end
				OP_BYTE_SHL: begin
					cond_nxt.shift_out                   = dst_v[8];
					cond_nxt.product_shift_overflow_flag = |dst_v[15:8];
					cond_nxt.product_precision_loss_flag = 1'b0;
					cond_nxt.operation_done_flag         = 1'b1;
				end
				OP_BYTE_SHR: begin
					cond_nxt.shift_out                   = dst_v[7];
					cond_nxt.product_shift_overflow_flag = 1'b0;
					cond_nxt.product_precision_loss_flag = |dst_v[7:0];
					cond_nxt.operation_done_flag         = 1'b1;
				end
				OP_TO_INT: cond_nxt.conv_sign = cmd.rst_sel ? dst_v[15] : cond_r.conv_sign ^ dst_v[15];
				default: ;
			endcase
			if (is_mul || is_wsh || is_rsh) begin
				cond_nxt.product_shift_overflow_flag = 1'b0;
				cond_nxt.product_precision_loss_flag = 1'b0;
				cond_nxt.shift_out                   = 1'b0;
				cond_nxt.operation_done_flag         = ~(is_mul | sh_start);
			end
		end
		if (sh_busy_r) begin
			cond_nxt.shift_out                    = sh_out;
			cond_nxt.product_shift_overflow_flag  = cond_r.product_shift_overflow_flag | sh_ovf;
			cond_nxt.product_precision_loss_flag  = cond_r.product_precision_loss_flag | (~sh_left_r & sh_out);
			if (sh_last)
				cond_nxt.operation_done_flag = 1'b1;
		end
		if (mul_done)
			cond_nxt.operation_done_flag = 1'b1;
	end

	// interrupt sources: an event in the clearing cycle still sets its bit
	wire              ar_ev = accept & is_addsub & (as_fl.unsigned_borrow_flag | as_fl.unsigned_carry_flag |
	                          as_fl.signed_under_flag | as_fl.signed_over_flag);
	wire [IRQ_W-1:0]  ev    = {ignored, ar_ev, mul_done | sh_last};
	wire [IRQ_W-1:0]  iclr  = (wr_en && hit_ist) ? pwdata[IRQ_W-1:0] : 3'h0;
	assign ist_nxt = (ist_r & ~iclr) | ev;
	assign irq     = |(ist_r & imsk_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_r    <= 1'b0;
			prdata_r <= 32'h0;
			imm_r    <= 16'h0000;
			prod_r   <= 32'h0;
			cond_r   <= mca_cond_t'(COND_RST);
			ist_r    <= 3'h0;
			imsk_r   <= 3'h0;
		end else begin
			ack_r  <= acc_ph & ~ack_r;
			cond_r <= cond_nxt;
			ist_r  <= ist_nxt;
			if (acc_ph && !ack_r)
				prdata_r <= rd_mux;
			if (wr_en && hit_imm)
				imm_r <= pwdata[DW-1:0];
			if (wr_en && hit_imsk)
				imsk_r <= pwdata[IRQ_W-1:0];
			if (mul_done)
				prod_r <= mul_prod;
			else if (sh_last && sh_wide_r)
				prod_r <= sh_val_nxt;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_add_one_cycle: assert property (
		accept && cmd.op == OP_ADD |=> reg_r[$past(cmd.dst)] == $past(as_res))
		else $error("add result not in destination one cycle later");
	a_flags_unsigned: assert property (
		accept && cmd.op inside {OP_SUB, OP_SUBI} &&
		cond_r.arith_mode_low_bit == 1'b0 && cond_r.arith_mode_high_bit == 1'b0
		|=> cond_r.ar.unsigned_borrow_flag == ($past(dst_v) < $past(opb)) && !cond_r.ar.signed_over_flag)
		else $error("unsigned subtract flags wrong");
	a_mul_latency: assert property (
		accept && is_mul |-> ##17 !cond_r.operation_done_flag ##1 cond_r.operation_done_flag)
		else $error("multiply done not after seventeen cycles");
	a_mul_product: assert property (
		accept && cmd.op == OP_MULI |-> ##18 prod_r == {16'h0000, $past(dst_v, 18)} * {28'h0, $past(cmd.imm, 18)})
		else $error("product register wrong after multiply");
	a_busy_ignore: assert property (
		launch && busy && !is_mode && !hit_ist |=> ist_r[IRQ_IGN] && $stable(imm_r))
		else $error("command while busy not flagged as ignored");
	a_mode_while_busy: assert property (
		launch && busy && is_mode |=> cond_r.arith_mode_low_bit == $past(cmd.imm[0]))
		else $error("mode set lost while busy");
	a_mask_and: assert property (
		accept && cmd.op == OP_AND |=> reg_r[$past(cmd.dst)] == ($past(dst_v) & $past(imm_r)))
		else $error("and mask result wrong");
	a_shift_cycles: assert property (
		accept && cmd.op == OP_SHLI && cmd.imm == 4'h4 |=> sh_busy_r [*4] ##1 !sh_busy_r)
		else $error("immediate shift did not take its amount in cycles");
	a_byte_shift: assert property (
		accept && cmd.op == OP_BYTE_SHL |=> !sh_busy_r && reg_r[$past(cmd.dst)] == {$past(dst_v[7:0]), 8'h00})
		else $error("byte shift wrong or slow");
	a_swap_bytes: assert property (
		accept && cmd.op == OP_SWAP |=> reg_r[$past(cmd.dst)] == {$past(dst_v[7:0]), $past(dst_v[15:8])})
		else $error("swap result wrong");
	a_to_twos_msb: assert property (
		accept && cmd.op == OP_TO_TWOS |=> reg_r[$past(cmd.dst)][15] == $past(cond_r.conv_sign))
		else $error("conversion msb not taken from sign bit");
	a_to_int_sign: assert property (
		accept && cmd.op == OP_TO_INT && !cmd.rst_sel |=> cond_r.conv_sign == ($past(cond_r.conv_sign) ^ $past(dst_v[15])))
		else $error("conversion sign not toggled");

	c_mul_done: cover property (accept && is_mul ##18 cond_r.operation_done_flag);
	c_long_shift: cover property (sh_start ##1 sh_busy_r [*4]);
	c_ignored: cover property (ignored);
	c_mode_busy: cover property (accept && is_mode && busy);
endmodule
`default_nettype wire

//--- logic/mca_mul.sv
// sequential shift-add multiplier, 16 x 16 into 32 bits
`default_nettype none
module mca_mul
	import mca_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          start,
	input  wire logic [DW-1:0] mcand,
	input  wire logic [DW-1:0] mplier,
	output logic               busy,
	output logic               done,
	output logic [PW-1:0]      product
);
	localparam logic [4:0] LAST = 5'(MUL_CYCLES);
	logic [4:0]    cnt_r;
	logic [PW-1:0] acc_r;
	logic [PW-1:0] mc_r;
	logic [DW-1:0] mp_r;

	assign busy    = cnt_r != 5'h00;
	assign done    = cnt_r == LAST;
	assign product = acc_r;

	// sixteen add steps and one hand-over step make up the latency
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 5'h00;
			acc_r <= 32'h0;
			mc_r  <= 32'h0;
			mp_r  <= 16'h0;
		end else if (start && !busy) begin
			cnt_r <= 5'h01;
			acc_r <= 32'h0;
			mc_r  <= {16'h0000, mcand};
			mp_r  <= mplier;
		end else if (done) begin
			cnt_r <= 5'h00;
		end else if (busy) begin
			if (mp_r[0])
				acc_r <= acc_r + mc_r;
			mc_r  <= {mc_r[PW-2:0], 1'b0};
			mp_r  <= {1'b0, mp_r[DW-1:1]};
			cnt_r <= cnt_r + 5'h01;
		end
	end
endmodule
`default_nettype wire

//--- test/mca_alu_bench.sv
// self-checking bench of the alu datapath driven through its register bus
`default_nettype none
module mca_alu_bench
	import mca_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [31:0] rv;
	logic        ev;
	int          error_cnt = 0;
	int          num_checks = 0;

	mca_alu mca_alu_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	mca_seq_model mca_seq_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		mca_seq_model_i.xfer(wr, a, d, rv, ev);
		if (mca_seq_model_i.tmo) begin
			error_cnt++;
			print_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		bus(1'b0, a, 32'h0);
		chk(nm, rv & m, e);
	endtask
	function automatic logic [7:0] ra(input int i);
		return OFF_REG0 + 8'(4 * i);
	endfunction
	task automatic cmd(input mca_op_t op, input logic [2:0] d, input logic [2:0] s, input logic [3:0] imm,
		input logic rs = 1'b0);
		mca_cmd_t c;
		c = '{rst_sel: rs, imm: imm, src: s, dst: d, op: op};
		wr(OFF_CMD, {16'h0, c});
	endtask
	// multi-cycle work is awaited through the done flag, never by a fixed delay
	task automatic wait_done();
		int n;
		for (n = 0; n < 40; n++) begin
			bus(1'b0, OFF_COND, 32'h0);
			if (rv[9] === 1'b1)
				break;
		end
		if (n == 40) begin
			error_cnt++;
			print_verdict();
		end
	endtask
	// one operation on register 1, then its result and the masked condition bits
	task automatic op1(input string nm, input mca_op_t op, input logic [15:0] v, input logic [2:0] s,
		input logic [3:0] imm, input logic rs, input logic [15:0] e, input logic [15:0] cm = 16'h0,
		input logic [15:0] ce = 16'h0);
		wr(ra(1), {16'h0, v});
		cmd(op, 3'd1, s, imm, rs);
		wait_done();
		rdc(nm, ra(1), {16'h0, e});
		rdc(nm, OFF_COND, {16'h0, ce}, {16'h0, cm});
	endtask

	initial begin
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc("cond_rst", OFF_COND, {16'h0, COND_RST});
		chk("irq_rst", {31'h0, irq}, 32'h0);
		wr(ra(1), 32'hffff);
		wr(ra(2), 32'h0002);
		cmd(OP_ADD, 3'd1, 3'd2, 4'h0);
		rdc("add_wrap", ra(1), 32'h0001);
		rdc("add_flags", OFF_COND, 32'h44, 32'h7f);
		wr(ra(3), 32'h0);
		cmd(OP_SUBI, 3'd3, 3'd0, 4'h1);
		rdc("subi_wrap", ra(3), 32'hffff);
		rdc("subi_flags", OFF_COND, 32'h18, 32'h3c);
		cmd(OP_SET_MODE, 3'd0, 3'd0, 4'h1);
		wr(ra(4), 32'h7fff);
		cmd(OP_ADDI, 3'd4, 3'd0, 4'h1);
		rdc("signed_sum", ra(4), 32'h8000);
		rdc("signed_flags", OFF_COND, 32'h1011, 32'h103f);
		wr(ra(5), 32'h5);
		cmd(OP_SUBI, 3'd5, 3'd0, 4'h5);
		rdc("zero_flag", OFF_COND, 32'h20, 32'h20);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		wr(OFF_IMSK, 32'h2);
		chk("irq_range", {31'h0, irq}, 32'h1);
		wr(OFF_IST, 32'h2);
		chk("irq_clear", {31'h0, irq}, 32'h0);
		cmd(OP_SET_MODE, 3'd0, 3'd0, 4'h0);
		// mask group, each result lands back in register 1
		wr(OFF_IMM, 32'h0ff0);
		op1("and", OP_AND, 16'h1234, 3'd0, 4'h0, 1'b0, 16'h0230);
		op1("or", OP_OR, 16'h1234, 3'd0, 4'h0, 1'b0, 16'h1ff4);
		op1("xor", OP_XOR, 16'h1234, 3'd0, 4'h0, 1'b0, 16'h1dc4);
		op1("not", OP_NOT, 16'h1234, 3'd0, 4'h0, 1'b0, 16'hedcb);
		// multiply, with an ignored command and a mode change while it runs
		wr(ra(1), 32'h0123);
		wr(ra(2), 32'h0100);
		wr(OFF_IMSK, 32'h5);
		cmd(OP_MUL, 3'd1, 3'd2, 4'h0);
		rdc("mul_busy", OFF_COND, 32'h0, 32'h200);
		cmd(OP_ADD, 3'd1, 3'd2, 4'h0);
		cmd(OP_SET_MODE, 3'd0, 3'd0, 4'h2);
		wait_done();
		rdc("mul_lo", OFF_PLO, 32'h2300);
		rdc("mul_hi", OFF_PHI, 32'h0001);
		rdc("ignored_add", ra(1), 32'h0123);
		rdc("mode_in_busy", OFF_COND, 32'h2000, 32'h3000);
		rdc("irq_status", OFF_IST, 32'h5, 32'h5);
		chk("irq_done", {31'h0, irq}, 32'h1);
		wr(OFF_IST, 32'h5);
		chk("irq_done_clr", {31'h0, irq}, 32'h0);
		cmd(OP_SET_MODE, 3'd0, 3'd0, 4'h0);
		cmd(OP_MULI, 3'd1, 3'd0, 4'hf);
		wait_done();
		rdc("muli_lo", OFF_PLO, 32'h110d);
		cmd(OP_WIDE_SHLI, 3'd0, 3'd0, 4'h8);
		wait_done();
		rdc("wshl_lo", OFF_PLO, 32'h0d00);
		rdc("wshl_hi", OFF_PHI, 32'h0011);
		wr(ra(2), 32'h4);
		cmd(OP_WIDE_SHR, 3'd0, 3'd2, 4'h0);
		wait_done();
		rdc("wshr_lo", OFF_PLO, 32'h10d0);
		wr(ra(1), 32'h1);
		cmd(OP_SHLI, 3'd1, 3'd0, 4'hf);
		rdc("shift_busy", OFF_COND, 32'h0, 32'h200);
		wait_done();
		rdc("shli15", ra(1), 32'h8000);
		op1("shli", OP_SHLI, 16'h8421, 3'd0, 4'h4, 1'b0, 16'h4210, 16'h480, 16'h80);
		op1("shri", OP_SHRI, 16'h8421, 3'd0, 4'h4, 1'b0, 16'h0842, 16'h500, 16'h100);
		op1("shl", OP_SHL, 16'h0001, 3'd2, 4'h0, 1'b0, 16'h0010);
		op1("shr", OP_SHR, 16'h0100, 3'd2, 4'h0, 1'b0, 16'h0010);
		op1("shls", OP_SHLS, 16'h0003, 3'd2, 4'h0, 1'b0, 16'h0030);
		op1("shrs", OP_SHRS, 16'hff00, 3'd2, 4'h0, 1'b0, 16'hfff0);
		op1("shlsi", OP_SHLSI, 16'h8001, 3'd0, 4'h1, 1'b0, 16'h8002);
		op1("shrsi", OP_SHRSI, 16'h8000, 3'd0, 4'h2, 1'b0, 16'he000);
		op1("bshl", OP_BYTE_SHL, 16'h1234, 3'd0, 4'h0, 1'b0, 16'h3400, 16'h80, 16'h80);
		op1("bshr", OP_BYTE_SHR, 16'h1234, 3'd0, 4'h0, 1'b0, 16'h0012, 16'h100, 16'h100);
		op1("swap", OP_SWAP, 16'h1234, 3'd0, 4'h0, 1'b0, 16'h3412);
		op1("to_twos_complement_op_a", OP_TO_TWOS, 16'h8005, 3'd0, 4'h0, 1'b0, 16'h0005);
		op1("toint_a", OP_TO_INT, 16'h8003, 3'd0, 4'h0, 1'b1, 16'h0003, 16'h800, 16'h800);
		op1("to_twos_complement_op_b", OP_TO_TWOS, 16'h0005, 3'd0, 4'h0, 1'b0, 16'h8005);
		op1("toint_b", OP_TO_INT, 16'h8001, 3'd0, 4'h0, 1'b0, 16'h0001, 16'h800, 16'h0);
		// bus refusals at unmapped and misaligned places; the write-only command word reads back as zero
		rdc("unmapped", 8'h1c, 32'h0);
		chk("unmapped_err", {31'h0, ev}, 32'h1);
		rdc("misaligned", 8'h05, 32'h0);
		chk("misaligned_err", {31'h0, ev}, 32'h1);
		rdc("cmd_read", OFF_CMD, 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire

//--- test/mca_seq_model.sv
// sequencer model: apb master that issues alu commands and reads results back
`default_nettype none
module mca_seq_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tmo = 1'b0;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// pready, read data and error are all taken at the rising edge that completes the access
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int   n;
		logic got;
		got = 1'b0;
		rd = 32'h0;
		er = 1'b1;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20 && !got; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				rd = prdata;
				er = pslverr;
				got = 1'b1;
			end
		end
		if (!got)
			tmo = 1'b1;
		// released address and data lines carry inverted values so a late sample cannot pass by luck
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge pclk);
	endtask
endmodule
`default_nettype wire
